// ===== include/lrt_defines.svh
`ifndef LRT_DEFINES_SVH
`define LRT_DEFINES_SVH

// register page offsets
`define LRT_A_SEC       10'h200
`define LRT_A_MIN       10'h201
`define LRT_A_HOUR      10'h202
`define LRT_A_WDAY      10'h203
`define LRT_A_DATE      10'h204
`define LRT_A_MON       10'h205
`define LRT_A_YEAR      10'h206
`define LRT_A_AL_SEC    10'h207
`define LRT_A_AL_MIN    10'h208
`define LRT_A_AL_HOUR   10'h209
`define LRT_A_AL_WDAY   10'h20A
`define LRT_A_TLOW      10'h20B
`define LRT_A_THIGH     10'h20C
`define LRT_A_SAMPLE    10'h20D
`define LRT_A_CTRL      10'h20E
`define LRT_A_TEMP      10'h211

// writable bit masks; bits outside read as zero
`define LRT_M_SEC       8'h7F
`define LRT_M_MIN       8'h7F
`define LRT_M_HOUR      8'h7F
`define LRT_M_WDAY      8'h07
`define LRT_M_DATE      8'h3F
`define LRT_M_MON       8'h9F
`define LRT_M_YEAR      8'hFF
`define LRT_M_ALARM     8'hFF
`define LRT_M_AL_WDAY   8'h87
`define LRT_M_CTRL      8'hDF

// field positions
`define LRT_B_MASK      7
`define LRT_B_H12       6
`define LRT_B_PM        5
`define LRT_B_CENTURY_FLAG      7
`define LRT_B_OSC_STOP  7
`define LRT_B_CLR_EN    6
`define LRT_B_MIS_EN_N  4
`define LRT_B_WRAP      3
`define LRT_B_TLS       2
`define LRT_B_THS       1
`define LRT_B_TAS       0

// reset values
`define LRT_R_ZERO      8'h00
`define LRT_R_ONE       8'h01
`define LRT_R_CTRL      8'h00

// BCD limits and codes
`define LRT_BCD_59      8'h59
`define LRT_BCD_23      8'h23
`define LRT_BCD_11      8'h11
`define LRT_BCD_12      8'h12
`define LRT_BCD_99      8'h99
`define LRT_BCD_28      8'h28
`define LRT_BCD_29      8'h29
`define LRT_BCD_30      8'h30
`define LRT_BCD_31      8'h31
`define LRT_BCD_FEB     8'h02
`define LRT_BCD_WDAY_7  8'h07
`define LRT_T_UNDER     8'h00
`define LRT_T_OVER      8'hFF
`define LRT_T_MIN_OK    8'h01
`define LRT_T_MAX_OK    8'hFE

// timing
`define LRT_CLK_HZ      20000000
`define LRT_TICK_MS     1000
`define LRT_TICK_CYC    (`LRT_TICK_MS * (`LRT_CLK_HZ / 1000))

`endif

// ===== include/lrt_pkg.sv
package lrt_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } lrt_req_s;

    typedef struct packed {
        logic       valid;
        logic       under;
        logic       over;
        logic [7:0] code;
    } lrt_conv_s;
endpackage

// ===== rtl/lrt_regpage.sv
// Summary of operation
// - time, calendar and alarm registers hold BCD; host writes BCD.
// - fixed-zero bits of timekeeping registers always read zero.
// - during a mission first write to protected page ends it.
// - hours bit 6 one selects 12-hour mode, zero 24-hour.
// - hours bit 5 is PM in 12-hour mode, tens digit 20-23 otherwise.
// - weekday counts 1 to 7 with no fixed meaning.
// - February 29 exists when year is 00 or multiple of 4.
// - months bit 7 century flag toggles when year rolls 99 to 00.
// - four alarm registers carry mask bit 7 plus BCD compare value.
// - all masks zero: alarm when seconds, minutes, hours, weekday match.
// - masks select every second, seconds, minutes, or hours matching.
// - every clock alarm sets the timer alarm flag.
// - control search enables let pending alarms answer conditional search while a mission runs.
// - temperature is one byte in eighth degrees; 01h-FEh are valid.
// - under-range result stored 00h, over-range stored FFh.
// - temperature is code/8 plus offset of the range variant.
// - low and high threshold registers use the temperature code.
// - sample interval holds 1 to 255 minutes between conversions.
// - non-zero sample write starts mission if cleared and enabled.
// - control register is read/write; writing it ends a mission.
// - control bit 5 always reads zero and ignores writes.
// - control bit 7 zero runs oscillator, one stops it.
// - control bit 4 is active-low mission enable.
`include "lrt_defines.svh"

module lrt_regpage
    import lrt_pkg::*;
#(
    parameter int TICK_CYCLES = `LRT_TICK_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire lrt_req_s   req,
    input  wire lrt_conv_s  conv,
    input  wire logic       memory_cleared_flag,
    input  wire logic       taf_clear,
    output logic [7:0]      rd_data_q,
    output logic            mission_active_q,
    output logic            timer_alarm_flag_q,
    output logic            search_hit_q,
    output logic            osc_running_q,
    output logic            log_wrap_enable_q,
    output logic            clear_function_enable_q,
    output logic [7:0]      sample_interval_q
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
        return r;
    endfunction

    // 00 and every multiple of 4, read from both BCD digits
    function automatic logic is_leap(input logic [7:0] y);
        logic even_tens;
        even_tens = ~y[4];
        return even_tens ? (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)
                         : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] r;
        case (m)
            `LRT_BCD_FEB: r = is_leap(y) ? `LRT_BCD_29 : `LRT_BCD_28;
            8'h04, 8'h06, 8'h09, 8'h11: r = `LRT_BCD_30;
            default: r = `LRT_BCD_31;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic rst_m_q;
    logic rst_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q   <= rst_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  sec_q, min_q, hour_q, wday_q, date_q, mon_q, year_q;
    logic [7:0]  al_sec_q, al_min_q, al_hour_q, al_wday_q;
    logic [7:0]  tlow_q, thigh_q, ctrl_q, temp_q;
    logic [31:0] div_q;
    logic        adv_q;
    logic        chk_q;

    wire wr_sec   = req.wr && req.addr == `LRT_A_SEC;
    wire wr_min   = req.wr && req.addr == `LRT_A_MIN;
    wire wr_hour  = req.wr && req.addr == `LRT_A_HOUR;
    wire wr_wday  = req.wr && req.addr == `LRT_A_WDAY;
    wire wr_date  = req.wr && req.addr == `LRT_A_DATE;
    wire wr_mon   = req.wr && req.addr == `LRT_A_MON;
    wire wr_year  = req.wr && req.addr == `LRT_A_YEAR;
    wire wr_samp  = req.wr && req.addr == `LRT_A_SAMPLE;
    wire wr_ctrl  = req.wr && req.addr == `LRT_A_CTRL;
    wire wr_page  = req.wr && req.addr >= `LRT_A_SEC && req.addr <= `LRT_A_CTRL;

    wire osc_stop = ctrl_q[`LRT_B_OSC_STOP];
    wire tick_end = div_q == 32'(TICK_CYCLES - 1);
    // the one-second enable; a stopped oscillator holds the divider at zero
    wire tick     = tick_end && !osc_stop;

    ////////////////////////////////////////////////////////////////////////////
    // hour format
    wire       h12      = hour_q[`LRT_B_H12];
    wire       pm       = hour_q[`LRT_B_PM];
    wire [7:0] hr12     = {3'b000, hour_q[4:0]};
    wire [7:0] hr24     = {2'b00, hour_q[5:0]};
    wire       day_wrap = h12 ? (hr12 == `LRT_BCD_11 && pm) : (hr24 == `LRT_BCD_23);
    wire [7:0] hr12_nx  = (hr12 == `LRT_BCD_12) ? `LRT_R_ONE : bcd_inc(hr12);
    wire       pm_nx    = (hr12 == `LRT_BCD_11) ? ~pm : pm;
    wire [7:0] hour_nx  = h12 ? {1'b0, 1'b1, pm_nx, hr12_nx[4:0]}
                              : (day_wrap ? `LRT_R_ZERO : bcd_inc(hr24));

    wire c_min  = sec_q == `LRT_BCD_59;
    wire c_hour = c_min && min_q == `LRT_BCD_59;
    wire c_day  = c_hour && day_wrap;
    wire c_mon  = c_day && date_q == last_day({3'b000, mon_q[4:0]}, year_q);
    wire c_year = c_mon && {3'b000, mon_q[4:0]} == `LRT_BCD_12;
    wire c_century_flag = c_year && year_q == `LRT_BCD_99;
    // month digits only; the century flag in bit 7 is handled on its own
    wire [7:0] mon_inc = bcd_inc({3'b000, mon_q[4:0]});

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            div_q <= '0;
            adv_q <= 1'b0;
            chk_q <= 1'b0;
        end else begin
            div_q <= (tick_end || osc_stop) ? '0 : div_q + 32'h1;
            adv_q <= tick;
            chk_q <= adv_q;
        end
    end

    // writes are stored as given BCD, fixed-zero bits are masked
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            sec_q  <= `LRT_R_ZERO;
            min_q  <= `LRT_R_ZERO;
            hour_q <= `LRT_R_ZERO;
            wday_q <= `LRT_R_ONE;
            date_q <= `LRT_R_ONE;
            mon_q  <= `LRT_R_ONE;
            year_q <= `LRT_R_ZERO;
        end else begin
            // seconds advance per tick; a host write wins on its own byte
            if (wr_sec)
                sec_q <= req.wdata & `LRT_M_SEC;
            else if (tick)
                sec_q <= c_min ? `LRT_R_ZERO : bcd_inc(sec_q);
            if (wr_min)
                min_q <= req.wdata & `LRT_M_MIN;
            else if (tick && c_min)
                min_q <= c_hour ? `LRT_R_ZERO : bcd_inc(min_q);
            if (wr_hour)
                hour_q <= req.wdata & `LRT_M_HOUR;
            else if (tick && c_hour)
                hour_q <= hour_nx;
            if (wr_wday)
                wday_q <= req.wdata & `LRT_M_WDAY;
            else if (tick && c_day)
                wday_q <= (wday_q == `LRT_BCD_WDAY_7) ? `LRT_R_ONE : wday_q + 8'h01;
            if (wr_date)
                date_q <= req.wdata & `LRT_M_DATE;
            else if (tick && c_day)
                date_q <= c_mon ? `LRT_R_ONE : bcd_inc(date_q);
            if (wr_mon)
                mon_q <= req.wdata & `LRT_M_MON;
            else if (tick && c_mon) begin
                mon_q[4:0] <= c_year ? 5'h01 : mon_inc[4:0];
                // century flag toggles on 99 to 00
                if (c_century_flag)
                    mon_q[`LRT_B_CENTURY_FLAG] <= ~mon_q[`LRT_B_CENTURY_FLAG];
            end
            if (wr_year)
                year_q <= req.wdata & `LRT_M_YEAR;
            else if (tick && c_year)
                year_q <= c_century_flag ? `LRT_R_ZERO : bcd_inc(year_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm bytes: mask in bit 7, BCD value below
    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            al_sec_q  <= `LRT_R_ZERO;
            al_min_q  <= `LRT_R_ZERO;
            al_hour_q <= `LRT_R_ZERO;
            al_wday_q <= `LRT_R_ZERO;
            tlow_q    <= `LRT_R_ZERO;
            thigh_q   <= `LRT_R_ZERO;
        end else if (req.wr) begin
            case (req.addr)
                `LRT_A_AL_SEC:  al_sec_q  <= req.wdata & `LRT_M_ALARM;
                `LRT_A_AL_MIN:  al_min_q  <= req.wdata & `LRT_M_ALARM;
                `LRT_A_AL_HOUR: al_hour_q <= req.wdata & `LRT_M_ALARM;
                `LRT_A_AL_WDAY: al_wday_q <= req.wdata & `LRT_M_AL_WDAY;
                `LRT_A_TLOW:    tlow_q    <= req.wdata;
                `LRT_A_THIGH:   thigh_q   <= req.wdata;
                default: ;
            endcase
        end
    end

    // a set mask makes its field always match
    wire m_sec  = al_sec_q[`LRT_B_MASK]  || al_sec_q[6:0]  == sec_q[6:0];
    wire m_min  = al_min_q[`LRT_B_MASK]  || al_min_q[6:0]  == min_q[6:0];
    wire m_hour = al_hour_q[`LRT_B_MASK] || al_hour_q[6:0] == hour_q[6:0];
    wire m_wday = al_wday_q[`LRT_B_MASK] || al_wday_q[6:0] == wday_q[6:0];
    wire alarm  = chk_q && m_sec && m_min && m_hour && m_wday;

    ////////////////////////////////////////////////////////////////////////////
    wire start_ok = wr_samp && req.wdata != `LRT_R_ZERO && memory_cleared_flag
                    && !ctrl_q[`LRT_B_MIS_EN_N] && !mission_active_q;
    wire in_range = temp_q >= `LRT_T_MIN_OK && temp_q <= `LRT_T_MAX_OK;

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            ctrl_q             <= `LRT_R_CTRL;
            sample_interval_q  <= `LRT_R_ZERO;
            mission_active_q   <= 1'b0;
            timer_alarm_flag_q <= 1'b0;
            temp_q             <= `LRT_R_ZERO;
        end else begin
            // control writes end a mission; bit 5 never stores
            if (wr_ctrl)
                ctrl_q <= req.wdata & `LRT_M_CTRL;
            // interval is read-only while a mission runs
            if (wr_samp && !mission_active_q)
                sample_interval_q <= req.wdata;
            // mission start, any page write ends it
            if (start_ok)
                mission_active_q <= 1'b1;
            else if (wr_page)
                mission_active_q <= 1'b0;
            // alarm sets the flag; a set in the clear cycle wins
            if (alarm)
                timer_alarm_flag_q <= 1'b1;
            else if (taf_clear)
                timer_alarm_flag_q <= 1'b0;
            // out-of-range codes pin to 00h or FFh
            if (conv.valid)
                temp_q <= conv.under ? `LRT_T_UNDER
                        : conv.over ? `LRT_T_OVER
                        : (conv.code == `LRT_T_UNDER) ? `LRT_T_MIN_OK
                        : (conv.code == `LRT_T_OVER) ? `LRT_T_MAX_OK : conv.code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the code is kept raw; the offset is applied by software per variant
    logic [7:0] rd_mux;
    logic [9:0] rd_addr_q;

    always_comb begin
        case (req.addr)
            `LRT_A_SEC:     rd_mux = sec_q;
            `LRT_A_MIN:     rd_mux = min_q;
            `LRT_A_HOUR:    rd_mux = hour_q;
            `LRT_A_WDAY:    rd_mux = wday_q;
            `LRT_A_DATE:    rd_mux = date_q;
            `LRT_A_MON:     rd_mux = mon_q;
            `LRT_A_YEAR:    rd_mux = year_q;
            `LRT_A_AL_SEC:  rd_mux = al_sec_q;
            `LRT_A_AL_MIN:  rd_mux = al_min_q;
            `LRT_A_AL_HOUR: rd_mux = al_hour_q;
            `LRT_A_AL_WDAY: rd_mux = al_wday_q;
            `LRT_A_TLOW:    rd_mux = tlow_q;
            `LRT_A_THIGH:   rd_mux = thigh_q;
            `LRT_A_SAMPLE:  rd_mux = sample_interval_q;
            `LRT_A_CTRL:    rd_mux = ctrl_q;
            `LRT_A_TEMP:    rd_mux = temp_q;
            default:        rd_mux = `LRT_R_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            rd_data_q               <= `LRT_R_ZERO;
            rd_addr_q               <= '0;
            search_hit_q            <= 1'b0;
            osc_running_q           <= 1'b0;
            log_wrap_enable_q       <= 1'b0;
            clear_function_enable_q <= 1'b0;
        end else begin
            rd_data_q               <= rd_mux;
            rd_addr_q               <= req.addr;
            search_hit_q            <= mission_active_q &&
                                       ((ctrl_q[`LRT_B_TAS] && timer_alarm_flag_q) ||
                                        (ctrl_q[`LRT_B_TLS] && in_range && temp_q <= tlow_q) ||
                                        (ctrl_q[`LRT_B_THS] && in_range && temp_q >= thigh_q));
            osc_running_q           <= !osc_stop;
            log_wrap_enable_q       <= ctrl_q[`LRT_B_WRAP];
            clear_function_enable_q <= ctrl_q[`LRT_B_CLR_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_wday_zero_bits: assert property (@(posedge ref_clk) disable iff (!rst_q)
        rd_addr_q == `LRT_A_WDAY |-> rd_data_q[7:3] == 5'h00)
        else $error("weekday read shows fixed-zero bits set");

    a_ctrl_bit5: assert property (@(posedge ref_clk) disable iff (!rst_q)
        rd_addr_q == `LRT_A_CTRL |-> !rd_data_q[5])
        else $error("control bit 5 read as one");

    a_mission_ends: assert property (@(posedge ref_clk) disable iff (!rst_q)
        mission_active_q && wr_page |=> !mission_active_q)
        else $error("page write during mission did not end it");

    a_mission_start: assert property (@(posedge ref_clk) disable iff (!rst_q)
        wr_samp && req.wdata != 8'h00 && memory_cleared_flag
        && !ctrl_q[4] && !mission_active_q |=> mission_active_q)
        else $error("valid sample write did not start mission");

    a_every_second: assert property (@(posedge ref_clk) disable iff (!rst_q)
        tick && al_sec_q[7] && al_min_q[7] && al_hour_q[7] && al_wday_q[7]
        && !req.wr ##1 !req.wr |-> ##2 timer_alarm_flag_q)
        else $error("all-masked alarm missed a second");

    a_hour_wrap24: assert property (@(posedge ref_clk) disable iff (!rst_q)
        tick && !req.wr && hour_q == 8'h23 && min_q == 8'h59 && sec_q == 8'h59
        |=> hour_q == 8'h00 && min_q == 8'h00)
        else $error("24-hour clock did not wrap at midnight");

    a_leap_day: assert property (@(posedge ref_clk) disable iff (!rst_q)
        tick && !req.wr && c_day && date_q == 8'h28 && mon_q[4:0] == 5'h02
        && year_q == 8'h96 |=> date_q == 8'h29)
        else $error("leap February 29 skipped");

    a_century_flip: assert property (@(posedge ref_clk) disable iff (!rst_q)
        tick && !req.wr && c_century_flag |=> mon_q[7] != $past(mon_q[7]) && year_q == 8'h00)
        else $error("century flag did not toggle at year rollover");

    a_temp_under: assert property (@(posedge ref_clk) disable iff (!rst_q)
        conv.valid && conv.under |=> temp_q == 8'h00)
        else $error("under-range result not stored as 00h");

    a_temp_over: assert property (@(posedge ref_clk) disable iff (!rst_q)
        conv.valid && conv.over && !conv.under |=> temp_q == 8'hFF)
        else $error("over-range result not stored as FFh");

    a_weekly_match: assert property (@(posedge ref_clk) disable iff (!rst_q)
        chk_q && al_sec_q == sec_q && al_min_q == min_q && al_hour_q == hour_q
        && al_wday_q == wday_q |=> timer_alarm_flag_q)
        else $error("full time match did not set the alarm flag");

    a_wday_wrap: assert property (@(posedge ref_clk) disable iff (!rst_q)
        tick && c_day && !wr_wday && wday_q == 8'h07 |=> wday_q == 8'h01)
        else $error("weekday did not wrap from 7 to 1");

    a_noon_12h: assert property (@(posedge ref_clk) disable iff (!rst_q)
        tick && c_hour && !wr_hour && hour_q == 8'h51 |=> hour_q == 8'h72)
        else $error("12-hour clock did not step 11 AM to 12 PM");

    a_ctrl_ends: assert property (@(posedge ref_clk) disable iff (!rst_q)
        mission_active_q && wr_ctrl
        |=> !mission_active_q && ctrl_q == ($past(req.wdata) & `LRT_M_CTRL))
        else $error("control write in mission did not end it and update");

endmodule

// ===== verif/lrt_host_model.sv
module lrt_host_model
    import lrt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data_q,
    output lrt_req_s        req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req = '{1'b0, 10'h200, 8'h00};
    end

    task automatic put(input logic [9:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        req <= '{1'b1, addr, data};
        @(posedge ref_clk);
        req.wr    <= 1'b0;
        // a released data line must not keep showing the last byte
        req.wdata <= ~data;
    endtask

    task automatic get(input logic [9:0] addr, output logic [7:0] data);
        @(posedge ref_clk);
        req.addr <= addr;
        @(posedge ref_clk);
        #1;
        data = rd_data_q;
    endtask
endmodule

// ===== verif/testbench.sv
`include "lrt_defines.svh"

module testbench import lrt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // rows: hr wd date mon yr, then the same after one tick
    localparam logic [79:0]  CAL [8] = '{80'h2307280296_0001290296, 80'h2303280299_0004010399,
        80'h2301288200_0002298200, 80'h2307311299_0001018100, 80'h2307319299_0001010100,
        80'h2302308400_0003018500, 80'h5102100501_7202100501, 80'h1902100501_2002100501};
    // rows: four alarm bytes, four time bytes, expected flag
    localparam logic [71:0]  ALM [9] = '{72'h80808080_00000001_01, 72'h12808080_10000001_00,
        72'h12808080_11000001_01, 72'h12348080_11340001_01, 72'h12348080_11330001_00,
        72'h12340580_11340501_01, 72'h12340580_11340601_00, 72'h12340503_11340503_01,
        72'h12340503_11340504_00};
    localparam logic [127:0] MASKS = 128'h7F7F7F07_3F9FFFFF_FFFF87FF_FFFFDF00;
    localparam logic [127:0] RSTV  = 128'h00000001_01010000_00000000_00008000;
    localparam logic [19:0]  TMP [6] = '{20'h2AA00, 20'h155FF, 20'h00001, 20'h0FFFE,
        20'h08080, 20'h04040};
    localparam logic [7:0]   SRCH [3] = '{8'h01, 8'h04, 8'h02};

    logic       ref_clk;
    logic       rst_n;
    lrt_req_s   req;
    lrt_conv_s  conv;
    logic       memory_cleared_flag;
    logic       taf_clear;
    logic [7:0] rd_data_q;
    logic       mission_active_q;
    logic       timer_alarm_flag_q;
    logic       search_hit_q;
    logic       osc_running_q;
    logic       log_wrap_enable_q;
    logic       clear_function_enable_q;
    logic [7:0] sample_interval_q;
    logic [7:0] rd;
    int         fails;
    int         checks_done;

    lrt_regpage #(.TICK_CYCLES(20)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
        .conv(conv), .memory_cleared_flag(memory_cleared_flag), .taf_clear(taf_clear),
        .rd_data_q(rd_data_q), .mission_active_q(mission_active_q),
        .timer_alarm_flag_q(timer_alarm_flag_q), .search_hit_q(search_hit_q),
        .osc_running_q(osc_running_q), .log_wrap_enable_q(log_wrap_enable_q),
        .clear_function_enable_q(clear_function_enable_q),
        .sample_interval_q(sample_interval_q));

    lrt_host_model host (.ref_clk(ref_clk), .rd_data_q(rd_data_q), .req(req));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // runs the oscillator for exactly one second step, then stops it again
    task automatic one_tick();
        logic [7:0] s0;
        int         n;
        host.get(`LRT_A_SEC, s0);
        rd = s0;
        n = 0;
        host.put(`LRT_A_CTRL, 8'h00);
        while (rd === s0 && n < 100) begin
            host.get(`LRT_A_SEC, rd);
            n++;
        end
        host.put(`LRT_A_CTRL, 8'h80);
        check("second tick", {7'h00, n < 100}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset values, fixed zeros
    task automatic register_map();
        check("osc after reset", {7'h00, osc_running_q}, 8'h01);
        host.put(`LRT_A_CTRL, 8'h80);
        for (int i = 0; i < 16; i++) begin
            host.get(`LRT_A_SEC + 10'(i), rd);
            check("reset value", rd, RSTV[127-8*i -: 8]);
        end
        for (int i = 0; i < 16; i++) begin
            host.put(`LRT_A_SEC + 10'(i), 8'hFF);
            host.get(`LRT_A_SEC + 10'(i), rd);
            check("fixed zero bits", rd, MASKS[127-8*i -: 8]);
        end
        check("osc stopped", {7'h00, osc_running_q}, 8'h00);
        check("wrap copy", {7'h00, log_wrap_enable_q}, 8'h01);
        check("clear enable copy", {7'h00, clear_function_enable_q}, 8'h01);
    endtask

    // carries from 59:59, century set for 20xx years
    task automatic calendar_rollover();
        logic [79:0] r;
        for (int i = 0; i < 8; i++) begin
            r = CAL[i];
            host.put(`LRT_A_SEC, 8'h59);
            host.put(`LRT_A_MIN, 8'h59);
            for (int k = 0; k < 5; k++) host.put(`LRT_A_HOUR + 10'(k), r[79-8*k -: 8]);
            one_tick();
            for (int k = 0; k < 5; k++) begin
                host.get(`LRT_A_HOUR + 10'(k), rd);
                check("calendar byte", rd, r[39-8*k -: 8]);
            end
        end
    endtask

    task automatic alarm_masks();
        logic [71:0] r;
        for (int i = 0; i < 9; i++) begin
            r = ALM[i];
            for (int k = 0; k < 4; k++) begin
                host.put(`LRT_A_AL_SEC + 10'(k), r[71-8*k -: 8]);
                host.put(`LRT_A_SEC + 10'(k), r[39-8*k -: 8]);
            end
            @(posedge ref_clk);
            taf_clear <= 1'b1;
            @(posedge ref_clk);
            taf_clear <= 1'b0;
            one_tick();
            repeat (4) @(posedge ref_clk);
            check("alarm flag", {7'h00, timer_alarm_flag_q}, r[7:0]);
        end
    endtask

    task automatic temperature_codes();
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            conv <= '{1'b1, TMP[i][17], TMP[i][16], TMP[i][15:8]};
            @(posedge ref_clk);
            conv.valid <= 1'b0;
            host.get(`LRT_A_TEMP, rd);
            check("temperature code", rd, TMP[i][7:0]);
        end
    endtask

    task automatic mission_cycle();
        logic [9:0] ends [3];
        ends = '{`LRT_A_SAMPLE, `LRT_A_CTRL, `LRT_A_SEC};
        for (int k = 0; k < 4; k++) host.put(`LRT_A_AL_SEC + 10'(k), 8'h80);
        one_tick();
        @(posedge ref_clk);
        memory_cleared_flag <= 1'b1;
        host.put(`LRT_A_TLOW, 8'h44);
        host.put(`LRT_A_THIGH, 8'h50);
        host.put(`LRT_A_CTRL, 8'h10);
        host.put(`LRT_A_SAMPLE, 8'h05);
        repeat (2) @(posedge ref_clk);
        check("mission while disabled", {7'h00, mission_active_q}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            host.put(`LRT_A_CTRL, SRCH[i]);
            host.put(`LRT_A_SAMPLE, 8'h00);
            repeat (2) @(posedge ref_clk);
            check("mission on zero", {7'h00, mission_active_q}, 8'h00);
            host.put(`LRT_A_SAMPLE, 8'h05);
            repeat (3) @(posedge ref_clk);
            check("mission started", {7'h00, mission_active_q}, 8'h01);
            check("search hit", {7'h00, search_hit_q}, {7'h00, i != 2});
            host.get(`LRT_A_CTRL, rd);
            check("control in mission", rd, SRCH[i]);
            host.put(ends[i], SRCH[i]);
            repeat (2) @(posedge ref_clk);
            check("mission ended", {7'h00, mission_active_q}, 8'h00);
            check("sample interval", sample_interval_q, 8'h05);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        conv = '0;
        memory_cleared_flag = 1'b0;
        taf_clear = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        register_map();
        calendar_rollover();
        alarm_masks();
        temperature_codes();
        mission_cycle();
        final_report();
    end

    // the whole run needs just over a thousand cycles; this leaves a wide margin
    initial begin
        repeat (30000) @(posedge ref_clk);
        fails++;
        final_report();
    end
endmodule
